// ### rps_pkg.sv
// Purpose: shared constants and types of the railroad preemption sequencer
// Assumes: 100 MHz clk_sys, one common timing tick for all interval timers
// Notes:   timing values are counts of ticks; register offsets are bytes
package rps_pkg;

  localparam int unsigned RPS_CLK_HZ     = 100_000_000;
  localparam int unsigned RPS_TICK_MS    = 100;
  localparam int unsigned RPS_TICK_CYC   = RPS_CLK_HZ / 1000 * RPS_TICK_MS;
  localparam int unsigned RPS_ONE_SEC_MS = 1000;
  localparam int unsigned RPS_TW         = 16;

  localparam logic [15:0] RPS_SEC_TICKS  = 16'(RPS_ONE_SEC_MS / RPS_TICK_MS);
  localparam logic [15:0] RPS_FAIL_TICKS = 16'(RPS_ONE_SEC_MS / RPS_TICK_MS + 1);

  // register offsets
  localparam logic [7:0] RPS_A_CTRL    = 8'h00;
  localparam logic [7:0] RPS_A_DELAY   = 8'h04;
  localparam logic [7:0] RPS_A_MINGRN  = 8'h08;
  localparam logic [7:0] RPS_A_TCG     = 8'h0c;
  localparam logic [7:0] RPS_A_MINHOLD = 8'h10;
  localparam logic [7:0] RPS_A_EXT     = 8'h14;
  localparam logic [7:0] RPS_A_OVLP    = 8'h18;
  localparam logic [7:0] RPS_A_CLR     = 8'h1c;
  localparam logic [7:0] RPS_A_CYC     = 8'h20;
  localparam logic [7:0] RPS_A_HOLDPH  = 8'h24;
  localparam logic [7:0] RPS_A_CRCDB   = 8'h28;
  localparam logic [7:0] RPS_A_STATUS  = 8'h2c;
  localparam logic [7:0] RPS_A_ALARM   = 8'h30;

  // values after reset
  localparam logic [4:0]  RPS_R_CTRL    = 5'h00;
  localparam logic [15:0] RPS_R_DELAY   = RPS_SEC_TICKS;
  localparam logic [15:0] RPS_R_MINGRN  = RPS_SEC_TICKS;
  localparam logic [15:0] RPS_R_TCG     = 16'h0064;
  localparam logic [15:0] RPS_R_MINHOLD = 16'h00c8;
  localparam logic [15:0] RPS_R_EXT     = 16'h0032;
  localparam logic [15:0] RPS_R_OVLP    = 16'h0032;
  localparam logic [15:0] RPS_R_CLR     = 16'h0028;
  localparam logic [15:0] RPS_R_CYC     = 16'h0064;
  localparam logic [7:0]  RPS_R_HOLDPH  = 8'h01;
  localparam logic [15:0] RPS_R_CRCDB   = 16'h0000;
  // pins at idle: secondary input on, module present, 24 V good
  localparam logic [22:0] RPS_R_SYNC    = 23'h190000;

  localparam logic [1:0] RPS_HM_REST   = 2'h0;
  localparam logic [1:0] RPS_HM_CYCLE  = 2'h1;
  localparam logic [1:0] RPS_HM_ALLRED = 2'h2;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_MINGRN = 7'h02,
    S_PRECLR = 7'h04,
    S_TCG    = 7'h08,
    S_HOLD   = 7'h10,
    S_EXTEND = 7'h20,
    S_FLASH  = 7'h40
  } rps_state_t;

  typedef struct packed {
    logic       presig;
    logic       secure;
    logic [1:0] holdMode;
    logic       nonLock;
  } rps_ctrl_t;

  typedef struct packed {
    logic v24Fail;
    logic crcFail;
    logic autoFlash;
    logic inFail;
    logic pre1Act;
  } rps_alarm_t;

endpackage : rps_pkg

// ### rps_timer.sv
// Purpose: loadable down-counter of timing ticks
// Assumes: tick is a one-cycle pulse on clk_sys
// Notes:   done is high while the count is zero; a load lands next edge
`timescale 1ns/1ns
module rps_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         run,
  input  wire logic [W-1:0] val,
  output logic              done
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= val;
    end else if (run && tick && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // done must not depend on load: callers derive load from done
  assign done = (cnt_q == '0);

endmodule : rps_timer

// ### rps_sequencer.sv
// Purpose: railroad preemption sequencing, input checks, check value watch
// Assumes: pins are asynchronous; phaseStart, intGreenEndReq, tcgOnIn and
//          otherPreReq come from controller logic on clk_sys
// Notes:   all intervals count the common tick; registers on a plain port
`timescale 1ns/1ns
module rps_sequencer import rps_pkg::*; #(
  parameter int unsigned TICK_CYCLES = RPS_TICK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  input  wire logic        busRemote,
  output logic      [31:0] rdData,
  input  wire logic        railPre1In,
  input  wire logic        railPre2In,
  input  wire logic        railPre2SecIn,
  input  wire logic        crcPresentIn,
  input  wire logic [15:0] crcModIn,
  input  wire logic        dbUnlockIn,
  input  wire logic        usbKeyIn,
  input  wire logic        volt24OkIn,
  input  wire logic        phaseStart,
  input  wire logic        intGreenEndReq,
  input  wire logic        tcgOnIn,
  input  wire logic        otherPreReq,
  output logic             phaseTerm,
  output logic             tcGreen,
  output logic      [7:0]  holdPhase,
  output logic             allRed,
  output logic             preSigGreen,
  output logic             preSigClear,
  output logic             intGreenEnd,
  output logic             otherPreGrant,
  output logic             blankOn,
  output logic             fmOk,
  output logic             forceFlash,
  output logic             alarmOut
);

  // pin synchronisers
  logic [22:0] syncA_q, syncB_q;
  logic        sup, pre2, pre2Sec, crcPres, unlocked, usbKey, v24Ok;
  logic [15:0] crcMod;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // idle levels, so no false input failure or module fault at start
      syncA_q <= RPS_R_SYNC;
      syncB_q <= RPS_R_SYNC;
    end else begin
      syncA_q <= {railPre1In, railPre2In, railPre2SecIn, crcPresentIn,
                  dbUnlockIn, usbKeyIn, volt24OkIn, crcModIn};
      syncB_q <= syncA_q;
    end
  end
  assign {sup, pre2, pre2Sec, crcPres, unlocked, usbKey, v24Ok, crcMod} =
    syncB_q;

  // common timing tick
  logic [31:0] tickCnt_q;
  logic        tick;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tickCnt_q <= '0;
    end else if (tick) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
    end
  end
  assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

  // software registers
  rps_ctrl_t   ctrl_q;
  rps_alarm_t  alarm_q, alarmSet;
  logic [15:0] delay_q, minGrn_q, tcgT_q, minHold_q, ext_q, ovlp_q;
  logic [15:0] clr_q, cyc_q, crcDb_q;
  logic [7:0]  holdPh_q;
  logic        wrOk;

  assign wrOk = wrEn && !(ctrl_q.secure && busRemote);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q    <= RPS_R_CTRL;
      delay_q   <= RPS_R_DELAY;
      minGrn_q  <= RPS_R_MINGRN;
      tcgT_q    <= RPS_R_TCG;
      minHold_q <= RPS_R_MINHOLD;
      ext_q     <= RPS_R_EXT;
      ovlp_q    <= RPS_R_OVLP;
      clr_q     <= RPS_R_CLR;
      cyc_q     <= RPS_R_CYC;
      holdPh_q  <= RPS_R_HOLDPH;
      crcDb_q   <= RPS_R_CRCDB;
    end else if (wrOk) begin
      case (addr)
        RPS_A_CTRL:    ctrl_q    <= wrData[4:0];
        RPS_A_DELAY:   delay_q   <= wrData[15:0];
        RPS_A_MINGRN:  minGrn_q  <= wrData[15:0];
        RPS_A_TCG:     tcgT_q    <= wrData[15:0];
        RPS_A_MINHOLD: minHold_q <= wrData[15:0];
        RPS_A_EXT:     ext_q     <= wrData[15:0];
        RPS_A_OVLP:    ovlp_q    <= wrData[15:0];
        RPS_A_CLR:     clr_q     <= wrData[15:0];
        RPS_A_CYC:     cyc_q     <= wrData[15:0];
        RPS_A_HOLDPH:  holdPh_q  <= wrData[7:0];
        RPS_A_CRCDB:   crcDb_q   <= wrData[15:0];
        default: ;
      endcase
    end
  end

  // demand filters and input supervision
  logic demDone, supDone, misDone, mis, dem, supQ, dem_q, sup_q;
  logic demRise, supRise, failLat_q, reqLat_q, req, flashPend, goPre;

  assign mis = (pre2 == pre2Sec);

  rps_timer #(.W(RPS_TW)) uDem (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(!pre2), .run(1'b1), .val(delay_q), .done(demDone));
  rps_timer #(.W(RPS_TW)) uSup (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(!sup), .run(1'b1), .val(delay_q), .done(supDone));
  rps_timer #(.W(RPS_TW)) uMis (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(!mis), .run(1'b1), .val(RPS_FAIL_TICKS), .done(misDone));

  assign dem     = pre2 && demDone;
  assign supQ    = sup && supDone;
  assign demRise = dem && !dem_q;
  assign supRise = supQ && !sup_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dem_q <= 1'b0;
      sup_q <= 1'b0;
    end else begin
      dem_q <= dem;
      sup_q <= supQ;
    end
  end

  // input failure needs a manual reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      failLat_q <= 1'b0;
    end else if (mis && misDone) begin
      failLat_q <= 1'b1;
    end
  end

  rps_state_t st_q, nxt;

  // locking demand memory; a new demand wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqLat_q <= 1'b0;
    end else if (demRise && !ctrl_q.nonLock) begin
      reqLat_q <= 1'b1;
    end else if (st_q == S_TCG || ctrl_q.nonLock) begin
      reqLat_q <= 1'b0;
    end
  end

  assign req       = ctrl_q.nonLock ? dem : (reqLat_q || dem);
  assign flashPend = failLat_q || supQ;
  assign goPre     = req || flashPend;

  // sequence and auxiliary timers
  logic        seqLoad, seqDone, mgDone, ovlDone, cycDone, crcDone;
  logic [15:0] seqVal;
  logic        ovlActive_q, ovlLoad;

  rps_timer #(.W(RPS_TW)) uSeq (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(seqLoad), .run(1'b1), .val(seqVal), .done(seqDone));
  rps_timer #(.W(RPS_TW)) uMg (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(phaseStart), .run(1'b1), .val(minGrn_q), .done(mgDone));
  rps_timer #(.W(RPS_TW)) uOvl (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(ovlLoad), .run(ovlActive_q), .val(ovlp_q), .done(ovlDone));
  rps_timer #(.W(RPS_TW)) uCyc (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(cycDone), .run(1'b1), .val(cyc_q), .done(cycDone));
  rps_timer #(.W(RPS_TW)) uCrc (.clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(crcDone), .run(1'b1), .val(RPS_SEC_TICKS), .done(crcDone));

  always_comb begin
    nxt     = st_q;
    seqLoad = 1'b0;
    seqVal  = tcgT_q;
    case (st_q)
      S_IDLE: begin
        if (goPre && ovlActive_q) begin
          nxt     = S_PRECLR;
          seqLoad = 1'b1;
          seqVal  = clr_q;
        end else if (goPre) begin
          nxt = S_MINGRN;
        end
      end
      S_MINGRN: begin
        if (ctrl_q.nonLock && !dem && !flashPend) begin
          nxt = S_IDLE;
        end else if (mgDone) begin
          nxt     = S_TCG;
          seqLoad = 1'b1;
        end
      end
      S_PRECLR: begin
        if (seqDone) begin
          nxt     = S_TCG;
          seqLoad = 1'b1;
        end
      end
      S_TCG: begin
        if (demRise || supRise) begin
          seqLoad = 1'b1;
        end else if (seqDone && flashPend) begin
          nxt = S_FLASH;
        end else if (seqDone) begin
          nxt     = S_HOLD;
          seqLoad = 1'b1;
          seqVal  = minHold_q;
        end
      end
      S_HOLD: begin
        if (demRise || supRise) begin
          nxt     = S_TCG;
          seqLoad = 1'b1;
        end else if (seqDone && !dem) begin
          nxt     = S_EXTEND;
          seqLoad = 1'b1;
          seqVal  = ext_q;
        end
      end
      S_EXTEND: begin
        if (demRise || supRise) begin
          nxt     = S_TCG;
          seqLoad = 1'b1;
        end else if (seqDone) begin
          nxt = S_IDLE;
        end
      end
      S_FLASH: begin
        if (!flashPend) begin
          nxt = S_IDLE;
        end
      end
      default: nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
    end else begin
      st_q <= nxt;
    end
  end

  // timed overlap of the pre-signal
  logic preSigOff_q;

  assign ovlLoad = intGreenEndReq && ctrl_q.presig && st_q == S_IDLE &&
                   !ovlActive_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovlActive_q <= 1'b0;
    end else if (ovlLoad) begin
      ovlActive_q <= 1'b1;
    end else if (ovlDone || nxt == S_PRECLR) begin
      ovlActive_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preSigOff_q <= 1'b0;
    end else if (ovlLoad) begin
      preSigOff_q <= 1'b1;
    end else if (phaseStart) begin
      preSigOff_q <= 1'b0;
    end
  end

  // hold display: rest, cycle among allowed phases, or all-red
  logic [2:0] cycIdx_q;
  logic [7:0] cycSel;

  assign cycSel = holdPh_q & (8'h01 << cycIdx_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cycIdx_q <= '0;
    end else if (cycDone || cycSel == 8'h00) begin
      cycIdx_q <= cycIdx_q + 3'h1;
    end
  end

  // signal outputs
  logic inHold;
  assign inHold = (nxt == S_HOLD || nxt == S_EXTEND);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phaseTerm     <= 1'b0;
      tcGreen       <= 1'b0;
      holdPhase     <= 8'h00;
      allRed        <= 1'b0;
      preSigGreen   <= 1'b0;
      preSigClear   <= 1'b0;
      intGreenEnd   <= 1'b0;
      otherPreGrant <= 1'b0;
      blankOn       <= 1'b0;
    end else begin
      phaseTerm   <= (st_q == S_MINGRN || st_q == S_IDLE) &&
                     (nxt == S_TCG || nxt == S_PRECLR);
      tcGreen     <= (nxt == S_TCG) ||
                     (tcgOnIn && (nxt == S_MINGRN || nxt == S_PRECLR));
      holdPhase   <= !inHold ? 8'h00 :
                     ctrl_q.holdMode == RPS_HM_REST  ? holdPh_q :
                     ctrl_q.holdMode == RPS_HM_CYCLE ? cycSel : 8'h00;
      allRed      <= inHold && ctrl_q.holdMode == RPS_HM_ALLRED;
      preSigGreen <= ctrl_q.presig && nxt == S_IDLE && !preSigOff_q;
      preSigClear <= nxt == S_PRECLR;
      intGreenEnd <= ctrl_q.presig ? (ovlActive_q && ovlDone)
                                   : (intGreenEndReq && st_q == S_IDLE);
      otherPreGrant <= otherPreReq && st_q == S_IDLE && !goPre &&
                       !ovlActive_q;
      blankOn     <= pre2;
    end
  end

  // check value supervision and lock handling
  logic crcFault_q, restartPend_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      crcFault_q    <= 1'b0;
      restartPend_q <= 1'b0;
      fmOk          <= 1'b0;
    end else begin
      if (!unlocked && !restartPend_q &&
          ((crcDone && crcMod != crcDb_q) || !crcPres)) begin
        crcFault_q <= 1'b1;
      end
      if (unlocked) begin
        restartPend_q <= 1'b1;
      end
      if (unlocked) begin
        fmOk <= 1'b0;
      end else if (crcPres && !usbKey) begin
        fmOk <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      forceFlash <= 1'b0;
    end else begin
      forceFlash <= st_q == S_FLASH || crcFault_q || restartPend_q ||
                    unlocked;
    end
  end

  // sticky alarms, write one to clear, a new event wins
  assign alarmSet = '{v24Fail: !v24Ok, crcFail: crcFault_q,
                      autoFlash: forceFlash, inFail: failLat_q,
                      pre1Act: supQ};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_q  <= '0;
      alarmOut <= 1'b0;
    end else begin
      if (wrEn && addr == RPS_A_ALARM) begin
        alarm_q <= (alarm_q & ~wrData[4:0]) | alarmSet;
      end else begin
        alarm_q <= alarm_q | alarmSet;
      end
      alarmOut <= |alarm_q;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      case (addr)
        RPS_A_CTRL:    rdData <= {27'h0, ctrl_q};
        RPS_A_DELAY:   rdData <= {16'h0, delay_q};
        RPS_A_MINGRN:  rdData <= {16'h0, minGrn_q};
        RPS_A_TCG:     rdData <= {16'h0, tcgT_q};
        RPS_A_MINHOLD: rdData <= {16'h0, minHold_q};
        RPS_A_EXT:     rdData <= {16'h0, ext_q};
        RPS_A_OVLP:    rdData <= {16'h0, ovlp_q};
        RPS_A_CLR:     rdData <= {16'h0, clr_q};
        RPS_A_CYC:     rdData <= {16'h0, cyc_q};
        RPS_A_HOLDPH:  rdData <= {24'h0, holdPh_q};
        RPS_A_CRCDB:   rdData <= {16'h0, crcDb_q};
        RPS_A_STATUS:  rdData <= {16'h0, crcMod[7:0], 1'b0, st_q} |
                                 {16'h0, 8'h0, 8'h0} |
                                 {8'h0, ovlActive_q, fmOk, crcFault_q,
                                  restartPend_q, failLat_q, dem, supQ,
                                  crcPres, 16'h0};
        RPS_A_ALARM:   rdData <= {27'h0, alarm_q};
        default:       rdData <= 32'h0;
      endcase
    end else begin
      rdData <= 32'h0;
    end
  end

  // helper: ticks seen while the raw demand stays high
  logic [15:0] hiTicks_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hiTicks_q <= '0;
    end else if (!pre2) begin
      hiTicks_q <= '0;
    end else if (tick && hiTicks_q != 16'hffff) begin
      hiTicks_q <= hiTicks_q + 16'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  dem_filter_a: assert property (dem |-> hiTicks_q >= delay_q)
    else $error("demand qualified before the delay elapsed");
  term_mingrn_a: assert property (phaseTerm && $past(st_q) == S_MINGRN
    |-> $past(mgDone))
    else $error("phase ended before preemption minimum green");
  tcg_keep_a: assert property (st_q == S_TCG && !seqDone |=> tcGreen)
    else $error("track clearance green dropped early");
  hold_rest_a: assert property (st_q == S_HOLD && dem && !demRise
    && !supRise |=> st_q == S_HOLD)
    else $error("hold left while demand present");
  all_red_a: assert property (st_q == S_HOLD && ctrl_q.holdMode ==
    RPS_HM_ALLRED && $past(st_q) == S_HOLD |-> allRed && holdPhase == 8'h00)
    else $error("all-red hold shows a phase");
  min_hold_a: assert property (st_q == S_HOLD && !seqDone
    |=> st_q inside {S_HOLD, S_TCG})
    else $error("hold left before minimum hold time");
  ext_reserv_a: assert property (st_q == S_EXTEND && demRise
    |=> st_q == S_TCG)
    else $error("demand in extension not re-serviced");
  ovl_stop_a: assert property (st_q == S_IDLE && ovlActive_q && goPre
    |=> st_q == S_PRECLR && !ovlActive_q ##1 preSigClear)
    else $error("overlap not stopped by rail demand");
  fm_drop_a: assert property (unlocked |=> !fmOk ##1 forceFlash)
    else $error("monitor signal held while unlocked");
  crc_flash_a: assert property ($rose(crcFault_q) |=> forceFlash [*2])
    else $error("check value fault without flash");
  grant_prio_a: assert property (otherPreGrant |-> $past(!goPre))
    else $error("lower preemption granted over railroad");

  tcg_seen_c:  cover property (st_q == S_MINGRN ##1 st_q == S_TCG);
  ext_seen_c:  cover property (st_q == S_HOLD ##1 st_q == S_EXTEND);
  reserv_c:    cover property (st_q == S_EXTEND ##1 st_q == S_TCG);
  crc_fault_c: cover property ($rose(crcFault_q));

endmodule : rps_sequencer

// ### rps_rail_model.sv
// Purpose: interconnect circuit and check module facing the sequencer
// Assumes: demand and crcBad come from the bench
// Notes:   secondary input is always the complement of the primary
`timescale 1ns/1ns
module rps_rail_model (
  input  wire logic        demand,
  input  wire logic        crcBad,
  output logic             pri,
  output logic             sec,
  output logic             present,
  output logic      [15:0] crcVal
);
  assign pri     = demand;
  assign sec     = ~demand;
  assign present = 1'b1;
  // module value matches the reset database value unless spoiled
  assign crcVal  = crcBad ? 16'h0001 : 16'h0000;
endmodule : rps_rail_model

// ### tb_rps_sequencer.sv
// Purpose: directed bench for the railroad preemption sequencer
// Assumes: tick shortened to 10 clocks, so one second is 100 clocks
// Notes:   bus reads compare rdData in the cycle after the strobe
`timescale 1ns/1ns
module tb_rps_sequencer import rps_pkg::*; ;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic [31:0] rdData;
  logic        wrEn = 1'b0;
  logic        rdEn = 1'b0;
  logic        busRemote = 1'b0;
  logic        demand = 1'b0;
  logic        crcBad = 1'b0;
  logic        volt24OkIn = 1'b1;
  logic        phaseStart = 1'b0;
  logic        tcgOnIn = 1'b0;
  logic [7:0]  holdPhase;
  logic        allRed;
  logic        otherPreReq = 1'b0;
  logic        railPre2In, railPre2SecIn, crcPresentIn;
  logic [15:0] crcModIn;
  logic        tcGreen, otherPreGrant, blankOn, fmOk, forceFlash, alarmOut;
  int          errors = 0;
  int          samples_checked = 0;
  int          i;

  always #5 clk_sys = ~clk_sys;

  rps_rail_model i_rail (.demand, .crcBad, .pri(railPre2In),
    .sec(railPre2SecIn), .present(crcPresentIn), .crcVal(crcModIn));

  rps_sequencer #(.TICK_CYCLES(10)) i_dut (.clk_sys, .rst, .addr,
    .wrData, .wrEn, .rdEn, .busRemote, .rdData, .railPre1In(1'b0),
    .railPre2In, .railPre2SecIn, .crcPresentIn, .crcModIn,
    .dbUnlockIn(1'b0), .usbKeyIn(1'b0), .volt24OkIn, .phaseStart,
    .intGreenEndReq(1'b0), .tcgOnIn, .otherPreReq, .phaseTerm(),
    .tcGreen, .holdPhase, .allRed, .preSigGreen(), .preSigClear(),
    .intGreenEnd(), .otherPreGrant, .blankOn, .fmOk, .forceFlash,
    .alarmOut);

  task automatic chk(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk_sys);
    wrEn   <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1 chk("rdData", rdData, e);
  endtask : rdc

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk("fmOk", fmOk, 1);
    chk("forceFlash", forceFlash, 0);
    rdc(RPS_A_DELAY, 32'(RPS_R_DELAY));
    rdc(RPS_A_MINGRN, 32'(RPS_R_MINGRN));
    rdc(8'h3c, 32'h0);
    // secure plus non-locking, then a refused remote download
    wr(RPS_A_CTRL, 32'h9);
    busRemote <= 1'b1;
    wr(RPS_A_DELAY, 32'h5);
    busRemote <= 1'b0;
    rdc(RPS_A_DELAY, 32'(RPS_R_DELAY));
    // short clearance, hold and extension keep the sequences brief
    wr(RPS_A_TCG, 32'h3);
    wr(RPS_A_MINHOLD, 32'h4);
    wr(RPS_A_EXT, 32'h14);
    @(posedge clk_sys) volt24OkIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk("alarmOut", alarmOut, 1);
    @(posedge clk_sys) volt24OkIn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(RPS_A_ALARM, 32'h10);
    repeat (3) @(posedge clk_sys);
    #1 chk("alarmOut", alarmOut, 0);
    // half-second demand must be filtered out
    @(posedge clk_sys) demand <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 chk("blankOn", blankOn, 1);
    repeat (45) @(posedge clk_sys);
    demand <= 1'b0;
    repeat (150) @(posedge clk_sys);
    #1 chk("tcGreen", tcGreen, 0);
    chk("blankOn", blankOn, 0);
    @(posedge clk_sys) otherPreReq <= 1'b1;
    phaseStart <= 1'b1;
    @(posedge clk_sys) phaseStart <= 1'b0;
    demand <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("otherPreGrant", otherPreGrant, 1);
    for (i = 0; i < 400 && tcGreen !== 1'b1; i++) @(negedge clk_sys);
    chk("tcGreen", tcGreen, 1);
    chk("tcDelay", 32'(i >= 85), 1);
    chk("otherPreGrant", otherPreGrant, 0);
    @(posedge clk_sys) demand <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk("blankOn", blankOn, 0);
    @(posedge clk_sys) crcBad <= 1'b1;
    for (i = 0; i < 300 && forceFlash !== 1'b1; i++) @(negedge clk_sys);
    chk("forceFlash", forceFlash, 1);
    chk("crcLatency", 32'(i < 130), 1);
    // long minimum green with clearance indications already on
    wr(RPS_A_MINGRN, 32'h1e);
    repeat (300) @(posedge clk_sys);
    demand     <= 1'b1;
    tcgOnIn    <= 1'b1;
    phaseStart <= 1'b1;
    @(posedge clk_sys) phaseStart <= 1'b0;
    repeat (200) @(posedge clk_sys);
    #1 chk("tcGreen", tcGreen, 1);
    repeat (200) @(posedge clk_sys);
    #1 chk("holdPhase", holdPhase, 32'h01);
    chk("allRed", allRed, 0);
    @(posedge clk_sys) demand <= 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 chk("holdPhase", holdPhase, 32'h01);
    @(posedge clk_sys) demand <= 1'b1;
    repeat (110) @(posedge clk_sys);
    #1 chk("tcGreen", tcGreen, 1);
    end_sim();
  end
endmodule : tb_rps_sequencer
